// file: uhosc_pkg.sv
package uhosc_pkg;

    // Register byte offsets on the APB port
    localparam logic [7:0] UHOSC_OFS_CTRL = 8'h00; // operating_mode_control
    localparam logic [7:0] UHOSC_OFS_STAT = 8'h04; // Sticky event status
    localparam logic [7:0] UHOSC_OFS_MASK = 8'h08; // Interrupt mask
    localparam logic [7:0] UHOSC_OFS_SRST = 8'h0C; // Software reset strobe

    // Host register interface command codes of the control register
    localparam logic [7:0] UHOSC_CMD_CTRL_RD = 8'h01;
    localparam logic [7:0] UHOSC_CMD_CTRL_WR = 8'h81;

    // Control register and reset strobe field positions
    localparam int UHOSC_BIT_RWE    = 10; // remote_wake_enable
    localparam int UHOSC_BIT_RWC    = 9;  // remote_wake_connected
    localparam int UHOSC_BIT_FS_HI  = 7;  // host_functional_state msb
    localparam int UHOSC_BIT_FS_LO  = 6;  // host_functional_state lsb
    localparam int UHOSC_BIT_SRST   = 0;  // Software reset request bit
    localparam logic [31:0] UHOSC_CTRL_LIVE = 32'h0000_06C0; // Implemented bits

    // Status and mask bit positions
    localparam int UHOSC_NEV        = 3;
    localparam int UHOSC_EV_FRAME   = 0;  // frame_start_flag
    localparam int UHOSC_EV_RESUME  = 1;  // Resume detected
    localparam int UHOSC_EV_WAKE    = 2;  // Remote wake-up signalled

    // Two-bit encodings of host_functional_state
    localparam logic [1:0] UHOSC_ENC_RESET  = 2'h0;
    localparam logic [1:0] UHOSC_ENC_RESUME = 2'h1;
    localparam logic [1:0] UHOSC_ENC_OPER   = 2'h2;
    localparam logic [1:0] UHOSC_ENC_SUSP   = 2'h3;

    // Timing
    localparam int UHOSC_PCLK_MHZ     = 50;
    localparam int UHOSC_SOF_DELAY_US = 1000; // 1 ms from entering operational
    localparam int UHOSC_SOF_CYCLES   = UHOSC_SOF_DELAY_US * UHOSC_PCLK_MHZ;
    localparam int UHOSC_PRST_US      = 10000; // Downstream reset after power-up
    localparam int UHOSC_PRST_CYCLES  = UHOSC_PRST_US * UHOSC_PCLK_MHZ;
    localparam int UHOSC_CNT_W        = 20;

    // One-hot functional states
    typedef enum logic [3:0] {
        UHOSC_FS_RESET  = 4'h1,
        UHOSC_FS_RESUME = 4'h2,
        UHOSC_FS_OPER   = 4'h4,
        UHOSC_FS_SUSP   = 4'h8
    } uhosc_fs_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } uhosc_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } uhosc_apb_rsp_t;

endpackage

// file: uhosc_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Remote wake enable, bit 10, read/write
// - Wake output when enable and resume detected
// - Wake enable reaches interrupt output only through the wake event
// - Connected bit 9: hard reset clears, soft keeps
// - State field bits 7:6, 00/01/10/11 encoding
// - Frame starts begin 1 ms after operational entry
// - Hardware alters state only while suspended
// - Suspend moves to resume on downstream resume
// - Soft or hard reset enters reset state
// - Only hard reset resets hub and ports
module uhosc_ctrl
    import uhosc_pkg::*;
#(
    parameter int SOF_CYCLES  = UHOSC_SOF_CYCLES,  // Delay and frame period
    parameter int PRST_CYCLES = UHOSC_PRST_CYCLES  // Downstream reset length
) (
    input  wire logic           pclk,             // Clock, 50 MHz
    input  wire logic           presetn,          // Hardware reset, active low
    input  wire logic           pclk_en,          // Clock enable, freezes state
    input  wire uhosc_apb_req_t apb_req,          // APB request
    output uhosc_apb_rsp_t      apb_rsp,          // APB answer
    input  wire logic           downstream_resume,// Resume seen on a port
    output logic                irq,              // Level interrupt
    output logic                remote_wake,      // Wake-up to host system
    output logic                sof_active,       // Frames being generated
    output logic                sof_pulse,        // One cycle per frame start
    output logic                root_hub_reset,   // Root hub held in reset
    output logic                port_reset        // Reset signalling on ports
);

    // Whole state of the block
    typedef struct packed {
        uhosc_fs_t                fs;
        logic                     remote_wake_enable;
        logic                     remote_wake_connected;
        logic [UHOSC_NEV-1:0]     status;
        logic [UHOSC_NEV-1:0]     mask;
        logic [UHOSC_CNT_W-1:0]   sof_cnt;
        logic                     sof_on;
        logic                     sof_pulse;
        logic [UHOSC_CNT_W-1:0]   prst_cnt;
        logic                     prst;
        logic                     irq;
        logic                     wake;
        uhosc_apb_rsp_t           rsp;
    } uhosc_state_t;

    uhosc_state_t s_reg;
    uhosc_state_t s_next;

    // Bus decode terms
    logic                 acc_first;
    logic                 take;
    logic                 wr_take;
    logic                 soft_rst;
    logic                 hit;
    logic [31:0]          rd_data;
    logic [1:0]           fs_enc;
    logic [UHOSC_NEV-1:0] ev_set;
    logic [UHOSC_NEV-1:0] ev_clr;

    // Encode one-hot state into its two-bit field
    function automatic logic [1:0] uhosc_enc(input uhosc_fs_t f);
        case (f)
            UHOSC_FS_RESET:  uhosc_enc = UHOSC_ENC_RESET;
            UHOSC_FS_RESUME: uhosc_enc = UHOSC_ENC_RESUME;
            UHOSC_FS_OPER:   uhosc_enc = UHOSC_ENC_OPER;
            UHOSC_FS_SUSP:   uhosc_enc = UHOSC_ENC_SUSP;
            default:         uhosc_enc = UHOSC_ENC_RESET;
        endcase
    endfunction

    // Decode the two-bit field written by software
    function automatic uhosc_fs_t uhosc_dec(input logic [1:0] e);
        case (e)
            UHOSC_ENC_RESET:  uhosc_dec = UHOSC_FS_RESET;
            UHOSC_ENC_RESUME: uhosc_dec = UHOSC_FS_RESUME;
            UHOSC_ENC_OPER:   uhosc_dec = UHOSC_FS_OPER;
            default:          uhosc_dec = UHOSC_FS_SUSP;
        endcase
    endfunction

    // Bus phase qualifiers; one wait state then the answer
    assign acc_first = apb_req.psel & apb_req.penable & ~s_reg.rsp.pready;
    assign take      = apb_req.psel & apb_req.penable & s_reg.rsp.pready;
    assign wr_take   = take & apb_req.pwrite;
    assign soft_rst  = wr_take & (apb_req.paddr == UHOSC_OFS_SRST)
                     & apb_req.pwdata[UHOSC_BIT_SRST];
    assign fs_enc    = uhosc_enc(s_reg.fs);

    // Read mux; reserved positions read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        hit     = 1'b1;
        case (apb_req.paddr)
            UHOSC_OFS_CTRL: begin
                rd_data[UHOSC_BIT_RWE]                   = s_reg.remote_wake_enable;
                rd_data[UHOSC_BIT_RWC]                   = s_reg.remote_wake_connected;
                rd_data[UHOSC_BIT_FS_HI:UHOSC_BIT_FS_LO] = fs_enc;
            end
            UHOSC_OFS_STAT: rd_data[UHOSC_NEV-1:0] = s_reg.status;
            UHOSC_OFS_MASK: rd_data[UHOSC_NEV-1:0] = s_reg.mask;
            UHOSC_OFS_SRST: rd_data = 32'h0000_0000;
            default:        hit = 1'b0;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        s_next           = s_reg;
        ev_set           = '0;
        ev_clr           = '0;
        s_next.sof_pulse = 1'b0;

        // Answer timing
        s_next.rsp.pready = acc_first;
        if (acc_first) begin
            s_next.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_data;
            s_next.rsp.pslverr = ~hit;
        end else begin
            s_next.rsp.prdata  = 32'h0000_0000;
            s_next.rsp.pslverr = 1'b0;
        end

        // Software writes; only live bits are kept
        if (wr_take && apb_req.paddr == UHOSC_OFS_CTRL) begin
            s_next.remote_wake_enable = apb_req.pwdata[UHOSC_BIT_RWE];
            s_next.remote_wake_connected = apb_req.pwdata[UHOSC_BIT_RWC];
            s_next.fs  = uhosc_dec(apb_req.pwdata[UHOSC_BIT_FS_HI:UHOSC_BIT_FS_LO]);
        end else if (s_reg.fs == UHOSC_FS_SUSP && downstream_resume) begin
            s_next.fs = UHOSC_FS_RESUME;
        end
        if (wr_take && apb_req.paddr == UHOSC_OFS_MASK) begin
            s_next.mask = apb_req.pwdata[UHOSC_NEV-1:0];
        end
        if (wr_take && apb_req.paddr == UHOSC_OFS_STAT) begin
            ev_clr = apb_req.pwdata[UHOSC_NEV-1:0];
        end

        // Frame start timing after operational entry
        if (s_next.fs != UHOSC_FS_OPER) begin
            s_next.sof_cnt = '0;
            s_next.sof_on  = 1'b0;
        end else if (s_reg.fs != UHOSC_FS_OPER) begin
            s_next.sof_cnt = '0;
        end else if (s_reg.sof_cnt == UHOSC_CNT_W'(SOF_CYCLES - 1)) begin
            s_next.sof_cnt   = '0;
            s_next.sof_on    = 1'b1;
            s_next.sof_pulse = 1'b1;
        end else begin
            s_next.sof_cnt = s_reg.sof_cnt + 1'b1;
        end

        // Events; a set wins over a clear in the same cycle
        ev_set[UHOSC_EV_FRAME]  = s_next.sof_pulse;
        ev_set[UHOSC_EV_RESUME] = downstream_resume;
        // Wake event on the rise of the next wake level
        ev_set[UHOSC_EV_WAKE]   = s_next.remote_wake_enable & ~s_reg.wake
                                & ((s_reg.status[UHOSC_EV_RESUME] & ~ev_clr[UHOSC_EV_RESUME])
                                | ev_set[UHOSC_EV_RESUME]);
        s_next.status = (s_reg.status & ~ev_clr) | ev_set;

        // Software reset keeps the connected bit and hub state
        if (soft_rst) begin
            s_next.fs        = UHOSC_FS_RESET;
            s_next.remote_wake_enable       = 1'b0;
            s_next.status    = '0;
            s_next.mask      = '0;
            s_next.sof_cnt   = '0;
            s_next.sof_on    = 1'b0;
            s_next.sof_pulse = 1'b0;
        end

        // Downstream reset signalling after hardware reset
        if (s_reg.prst) begin
            if (s_reg.prst_cnt == UHOSC_CNT_W'(PRST_CYCLES - 1)) begin
                s_next.prst = 1'b0;
            end else begin
                s_next.prst_cnt = s_reg.prst_cnt + 1'b1;
            end
        end

        // Registered outputs; wake enable reaches the interrupt only via the wake event
        s_next.irq  = |(s_next.status & s_next.mask);
        s_next.wake = s_next.remote_wake_enable & s_next.status[UHOSC_EV_RESUME];
    end

    // State register; hardware reset clears all, connected bit too, and sets prst
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg.fs        <= UHOSC_FS_RESET;
            s_reg.remote_wake_enable       <= 1'b0;
            s_reg.remote_wake_connected       <= 1'b0;
            s_reg.status    <= '0;
            s_reg.mask      <= '0;
            s_reg.sof_cnt   <= '0;
            s_reg.sof_on    <= 1'b0;
            s_reg.sof_pulse <= 1'b0;
            s_reg.prst_cnt  <= '0;
            s_reg.prst      <= 1'b1;
            s_reg.irq       <= 1'b0;
            s_reg.wake      <= 1'b0;
            s_reg.rsp       <= '0;
        end else if (pclk_en) begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp        = s_reg.rsp;
    assign irq            = s_reg.irq;
    assign remote_wake    = s_reg.wake;
    assign sof_active     = s_reg.sof_on;
    assign sof_pulse      = s_reg.sof_pulse;
    assign root_hub_reset = s_reg.prst;
    assign port_reset     = s_reg.prst;

    // Checks on enabled edges only
    default clocking cb @(posedge pclk iff pclk_en);
    endclocking
    default disable iff (!presetn);

    a_rwe_write: assert property (
        wr_take && apb_req.paddr == UHOSC_OFS_CTRL
        |=> s_reg.remote_wake_enable == $past(apb_req.pwdata[UHOSC_BIT_RWE]))
        else $error("wake enable not taken from write");

    a_wake_cause: assert property (
        remote_wake |-> s_reg.remote_wake_enable && s_reg.status[UHOSC_EV_RESUME])
        else $error("wake without enable and resume");

    a_irq_no_rwe: assert property (
        irq == |(s_reg.status & s_reg.mask))
        else $error("interrupt not set by masked status");

    a_srst_keeps: assert property (
        soft_rst |=> s_reg.remote_wake_connected == $past(s_reg.remote_wake_connected) && s_reg.fs == UHOSC_FS_RESET)
        else $error("soft reset changed connected bit");

    a_fs_field: assert property (
        acc_first && !apb_req.pwrite && apb_req.paddr == UHOSC_OFS_CTRL
        |=> apb_rsp.prdata[UHOSC_BIT_FS_HI:UHOSC_BIT_FS_LO] == $past(fs_enc))
        else $error("state field read back wrong");

    a_sof_wait: assert property (
        s_reg.fs == UHOSC_FS_OPER && $past(s_reg.fs) != UHOSC_FS_OPER
        |-> !sof_active [*8])
        else $error("frames began too early");

    a_sof_period: assert property (
        sof_pulse |-> s_reg.fs == UHOSC_FS_OPER && s_reg.sof_cnt == '0)
        else $error("frame start outside operational");

    a_hw_change: assert property (
        s_reg.fs != $past(s_reg.fs) && !$past(wr_take) && !$past(soft_rst)
        |-> $past(s_reg.fs) == UHOSC_FS_SUSP && s_reg.fs == UHOSC_FS_RESUME)
        else $error("hardware changed state outside suspend");

    a_reserved: assert property (
        apb_rsp.pready |-> (apb_rsp.prdata & ~UHOSC_CTRL_LIVE) == 32'h0000_0000
        || $past(apb_req.paddr) != UHOSC_OFS_CTRL)
        else $error("reserved control bits not zero");

    a_prst_hold: assert property (
        port_reset && s_reg.prst_cnt < UHOSC_CNT_W'(PRST_CYCLES - 1) |=> port_reset)
        else $error("port reset ended early");

    c_oper_frames: cover property (sof_pulse);
    c_susp_resume: cover property (
        s_reg.fs == UHOSC_FS_SUSP ##1 s_reg.fs == UHOSC_FS_RESUME);
    c_wake: cover property ($rose(remote_wake));
    c_soft_rst: cover property (soft_rst && s_reg.fs == UHOSC_FS_OPER);

endmodule

// file: uhosc_port_model.sv
`timescale 1ns/1ns
module uhosc_port_model (
    input  wire logic pclk,              // Clock
    input  wire logic presetn,           // Hardware reset, active low
    input  wire logic resume_cmd,        // Bench asks for resume signalling
    output logic      downstream_resume  // Resume seen on a port
);
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;

    // Resume signalling held for three cycles, idle low otherwise
    always_comb begin
        cnt_next = cnt_reg;
        if (resume_cmd) begin
            cnt_next = 2'h3;
        end else if (cnt_reg != 2'h0) begin
            cnt_next = cnt_reg - 2'h1;
        end
    end

    // Counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign downstream_resume = (cnt_reg != 2'h0);
endmodule

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import uhosc_pkg::*;
    localparam int SOF_N  = 20;
    localparam int PRST_N = 16;
    logic           pclk;
    logic           presetn;
    logic           resume_cmd;
    logic           downstream_resume;
    logic           irq;
    logic           remote_wake;
    logic           sof_active;
    logic           sof_pulse;
    logic           root_hub_reset;
    logic           port_reset;
    logic           slverr;
    logic [31:0]    rdat;
    uhosc_apb_req_t req;
    uhosc_apb_rsp_t rsp;
    int             n_errors;
    int             num_checks;
    int             k;

    uhosc_ctrl #(.SOF_CYCLES(SOF_N), .PRST_CYCLES(PRST_N)) uhosc_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .apb_req(req), .apb_rsp(rsp),
        .downstream_resume(downstream_resume), .irq(irq), .remote_wake(remote_wake),
        .sof_active(sof_active), .sof_pulse(sof_pulse), .root_hub_reset(root_hub_reset),
        .port_reset(port_reset));

    uhosc_port_model uhosc_port_model_inst (.pclk(pclk), .presetn(presetn),
        .resume_cmd(resume_cmd), .downstream_resume(downstream_resume));

    // Clock, 20 ns period
    always #10 pclk = ~pclk;

    // Compare and count
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, holds the request until pready is sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rdat = rsp.prdata;
        slverr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Read and compare
    task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rdat, exp);
    endtask

    // Resume signalling from the port model, then settle
    task port_resume();
        resume_cmd <= 1'b1;
        @(posedge pclk);
        resume_cmd <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    task report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        resume_cmd = 1'b0;
        req = '0;
        n_errors = 0;
        num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("hub_reset", 32'(root_hub_reset), 32'h1);
        chk("port_reset", 32'(port_reset), 32'h1);
        rdc("ctrl_rst", UHOSC_OFS_CTRL, 32'h0);
        repeat (PRST_N) @(posedge pclk);
        chk("hub_rel", 32'(root_hub_reset | port_reset), 32'h0);
        apb(1'b1, UHOSC_OFS_CTRL, 32'hFFFF_FFFF);
        rdc("ctrl_live", UHOSC_OFS_CTRL, 32'h0000_06C0);
        // Every state encoding reads back
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, UHOSC_OFS_CTRL, 32'(i) << UHOSC_BIT_FS_LO);
            rdc("fs_enc", UHOSC_OFS_CTRL, 32'(i) << UHOSC_BIT_FS_LO);
        end
        // Suspended with wake enabled, interrupt masked
        apb(1'b1, UHOSC_OFS_MASK, 32'h0);
        apb(1'b1, UHOSC_OFS_CTRL, 32'h0000_04C0);
        port_resume();
        chk("wake", 32'(remote_wake), 32'h1);
        chk("irq_masked", 32'(irq), 32'h0);
        rdc("wake_event", UHOSC_OFS_STAT, 32'h0000_0006);
        rdc("to_resume", UHOSC_OFS_CTRL, 32'h0000_0440);
        apb(1'b1, UHOSC_OFS_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'(irq), 32'h1);
        apb(1'b1, UHOSC_OFS_STAT, 32'h7);
        repeat (2) @(posedge pclk);
        chk("irq_off", 32'(irq | remote_wake), 32'h0);
        // Operational entry, frame start delay counted in edges
        apb(1'b1, UHOSC_OFS_CTRL, 32'h0000_0080);
        k = 0;
        while (sof_pulse !== 1'b1 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        chk("sof_delay", k, SOF_N);
        chk("sof_active", 32'(sof_active), 32'h1);
        rdc("sof_flag", UHOSC_OFS_STAT, 32'h1);
        port_resume();
        rdc("oper_kept", UHOSC_OFS_CTRL, 32'h0000_0080);
        // Firmware marks wake connected, then software reset
        apb(1'b1, UHOSC_OFS_CTRL, 32'h0000_0680);
        apb(1'b1, UHOSC_OFS_SRST, 32'h1);
        rdc("soft_rst", UHOSC_OFS_CTRL, 32'h0000_0200);
        chk("hub_soft", 32'(root_hub_reset | port_reset), 32'h0);
        rdc("unmapped", 8'h10, 32'h0);
        chk("slverr", 32'(slverr), 32'h1);
        // Hardware reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("hub_hard", 32'(root_hub_reset & port_reset), 32'h1);
        rdc("hard_rst", UHOSC_OFS_CTRL, 32'h0);
        report_and_stop();
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end
endmodule
